/* File: shared/ppc_regs.svh */
// Purpose: constants for the power path and cable supply control block
// Assumes: core clock of 200 MHz
// Notes: nonvolatile defaults arrive as strap ports, caught after reset
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH
`define PPC_CLK_PERIOD_PS 5000
`define PPC_CS_DISCH_MS 250
`define PPC_CS_DISCH_CYCLES ((`PPC_CS_DISCH_MS * 64'd1000000000) / `PPC_CLK_PERIOD_PS)
`define PPC_UNDERVOLTAGE_LOCKOUT_HIGH_SEL 1'b1
`define PPC_UNDERVOLTAGE_LOCKOUT_LOW_SEL 1'b0
`define PPC_WIN_NOM_PCT 5
`define PPC_WIN_SHIFT_MAX_PCT 15
`define PPC_STATE_W 4
`endif

/* File: shared/ppc_pkg.sv */
// Purpose: types for the power path and cable supply control block
// Assumes: attach state codes come from the attach state machine
// Notes: none
package ppc_pkg;
  typedef enum logic [3:0] {
    PPC_UNATTACHED = 4'h0,
    PPC_ATT_WAIT_SRC = 4'h1,
    PPC_ATTACHED_SRC = 4'h2,
    PPC_UNOR_DBG_SRC = 4'h3,
    PPC_OR_DBG_SRC = 4'h4,
    PPC_ATT_WAIT_SNK = 4'h5,
    PPC_ATTACHED_SNK = 4'h6,
    PPC_DBG_SNK = 4'h7,
    PPC_ERR_RECOVERY = 4'h8,
    PPC_OTHER = 4'hF
  } ppc_attach_t;

  typedef enum logic [1:0] {
    PPC_ROLE_SRC = 2'h0,
    PPC_ROLE_SNK = 2'h1,
    PPC_ROLE_DRP = 2'h2
  } ppc_role_t;

  typedef struct packed {
    logic supply_above_uv;
    logic supply_below_ov;
    logic bus_in_window;
    logic bus_above_uv;
    logic bus_vsafe0v;
  } ppc_mon_t;

  typedef struct packed {
    logic supply_undervolt_check_en;
    logic supply_overvolt_check_en;
    logic bus_window_check_sel;
    logic cs_discharge_en;
    logic cs_undervoltage_lockout_high_sel;
  } ppc_cfg_t;

  typedef struct packed {
    logic drive_o;
    logic drive_oe;
  } ppc_od_t;
endpackage : ppc_pkg

/* File: hw/ppc_od_driver.sv */
// Purpose: open-drain style power-path enable pin driver
// Assumes: assert request is glitch free from one flop domain
// Notes: output level is always low; only the enable moves
`timescale 1ns/10ps
module ppc_od_driver
  import ppc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic assert_req,
  output ppc_od_t pin
);
  logic oe_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= assert_req;
    end
  end

  // low when asserted, released otherwise, never high
  assign pin.drive_o = 1'b0;
  assign pin.drive_oe = oe_r;
endmodule : ppc_od_driver

/* File: hw/ppc_disch_timer.sv */
// Purpose: one-shot timer for the cable supply discharge interval
// Assumes: start is a one-cycle pulse
// Notes: a new start restarts the interval
`timescale 1ns/10ps
module ppc_disch_timer #(
  parameter int unsigned CYCLES = 50000000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  output logic active
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("ppc_disch_timer: CYCLES must be at least 1");
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= CW'(CYCLES);
    end else if (abort) begin
      cnt_r <= '0;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  assign active = (cnt_r != '0);
endmodule : ppc_disch_timer

/* File: hw/ppc_power_path_ctrl.sv */
// Purpose: power path enables and cable supply control for a Type-C port
// Assumes: monitor comparator outputs are synchronous to core_clk
// Notes: config defaults except the cable lockout threshold are straps caught in the cycle after reset release
// Function
// - source enable low only in source states, conditions met
// - a failed state or bus condition releases enable to high impedance
// - source supply uv and ov checks when enabled
// - bus window check, else bus above uv
// - sink enable low in sink states, bus valid
// - supply checks only in source and DRP power roles
// - supply check enables default from straps, software writable
// - window selection defaults from straps, software writable
// - source enable holds while attached and bus valid
// - attached source entry only at vsafe0v on connect
// - cable supply needs role, switches, sink, Ra, undervoltage_lockout
// - no cable supply in sink power role
// - cable switch enabled only above supply lockout
// - cable lockout threshold defaults high, software selects low
// - source discharge for fixed interval after sink detach
// - discharge disabled unless strapped, software writable
// - bus window five percent plus programmable shift
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_power_path_ctrl
  import ppc_pkg::*;
#(
  parameter int unsigned DISCH_CYCLES = 32'(`PPC_CS_DISCH_CYCLES),
  parameter int unsigned SHIFT_W = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input ppc_attach_t cc_fsm_state_report,
  input ppc_role_t power_role,
  input ppc_mon_t mon,
  input ppc_cfg_t nvm_default,
  input wire logic sw_cfg_we,
  input ppc_cfg_t sw_cfg,
  input wire logic [SHIFT_W-1:0] nvm_win_high_shift,
  input wire logic [SHIFT_W-1:0] nvm_win_low_shift,
  input wire logic sw_shift_we,
  input wire logic [SHIFT_W-1:0] sw_win_high_shift,
  input wire logic [SHIFT_W-1:0] sw_win_low_shift,
  input wire logic connect_detect,
  input wire logic cs_switch_en,
  input wire logic sink_connected,
  input wire logic ra_on_cc1,
  input wire logic ra_on_cc2,
  input wire logic cc1_is_wired,
  input wire logic cable_supply_input_above_lockout,
  output ppc_od_t source_power_path_enable,
  output ppc_od_t sink_power_path_enable,
  output logic cs_to_cc1,
  output logic cs_to_cc2,
  output logic cs_discharge,
  output logic cs_undervoltage_lockout_high_sel,
  output logic [SHIFT_W:0] win_high_pct,
  output logic [SHIFT_W:0] win_low_pct,
  output logic src_entry_allowed,
  output ppc_cfg_t cfg_status
);

  // narrow shifts would overflow the percent sum
  if (SHIFT_W < 3 || SHIFT_W > 8) begin : g_bad_shift_w
    $error("ppc_power_path_ctrl: SHIFT_W out of range");
  end
  if (DISCH_CYCLES < 1) begin : g_bad_disch
    $error("ppc_power_path_ctrl: DISCH_CYCLES must be at least 1");
  end

  function automatic logic is_src_state(input ppc_attach_t s);
    is_src_state = (s == PPC_ATTACHED_SRC) || (s == PPC_UNOR_DBG_SRC) || (s == PPC_OR_DBG_SRC);
  endfunction : is_src_state

  function automatic logic is_snk_state(input ppc_attach_t s);
    is_snk_state = (s == PPC_ATTACHED_SNK) || (s == PPC_DBG_SNK);
  endfunction : is_snk_state

  function automatic logic [SHIFT_W:0] clamp_pct(input logic [SHIFT_W-1:0] sh);
    logic [SHIFT_W:0] v;
    v = {1'b0, sh};
    if (v > (SHIFT_W+1)'(`PPC_WIN_SHIFT_MAX_PCT)) begin
      v = (SHIFT_W+1)'(`PPC_WIN_SHIFT_MAX_PCT);
    end
    clamp_pct = v + (SHIFT_W+1)'(`PPC_WIN_NOM_PCT);
  endfunction : clamp_pct

  function automatic logic bus_cond(input ppc_cfg_t c, input ppc_mon_t m);
    bus_cond = c.bus_window_check_sel ? m.bus_in_window : m.bus_above_uv;
  endfunction : bus_cond

  function automatic logic supply_cond(input ppc_cfg_t c, input ppc_mon_t m, input logic src_role);
    logic ok;
    ok = 1'b1;
    if (src_role) begin
      if (c.supply_undervolt_check_en && !m.supply_above_uv) begin
        ok = 1'b0;
      end
      if (c.supply_overvolt_check_en && !m.supply_below_ov) begin
        ok = 1'b0;
      end
    end
    supply_cond = ok;
  endfunction : supply_cond

  function automatic logic cs_role_ok(input ppc_role_t r, input ppc_attach_t s);
    cs_role_ok = (r == PPC_ROLE_SRC || r == PPC_ROLE_DRP) && !is_snk_state(s);
  endfunction : cs_role_ok

  // configuration: strap capture after reset, then software writes
  logic boot_r;
  ppc_cfg_t cfg_r;
  logic uv_chk_en_r;
  logic ov_chk_en_r;
  logic win_sel_r;
  logic disch_en_r;
  logic undervoltage_lockout_high_r;
  logic [SHIFT_W-1:0] hi_shift_r;
  logic [SHIFT_W-1:0] lo_shift_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      uv_chk_en_r <= 1'b0;
    end else if (boot_r) begin
      uv_chk_en_r <= nvm_default.supply_undervolt_check_en;
    end else if (sw_cfg_we) begin
      uv_chk_en_r <= sw_cfg.supply_undervolt_check_en;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ov_chk_en_r <= 1'b0;
    end else if (boot_r) begin
      ov_chk_en_r <= nvm_default.supply_overvolt_check_en;
    end else if (sw_cfg_we) begin
      ov_chk_en_r <= sw_cfg.supply_overvolt_check_en;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_sel_r <= 1'b1;
    end else if (boot_r) begin
      win_sel_r <= nvm_default.bus_window_check_sel;
    end else if (sw_cfg_we) begin
      win_sel_r <= sw_cfg.bus_window_check_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      disch_en_r <= 1'b0;
    end else if (boot_r) begin
      disch_en_r <= nvm_default.cs_discharge_en;
    end else if (sw_cfg_we) begin
      disch_en_r <= sw_cfg.cs_discharge_en;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      undervoltage_lockout_high_r <= `PPC_UNDERVOLTAGE_LOCKOUT_HIGH_SEL;
    end else if (boot_r) begin
      undervoltage_lockout_high_r <= `PPC_UNDERVOLTAGE_LOCKOUT_HIGH_SEL;
    end else if (sw_cfg_we) begin
      undervoltage_lockout_high_r <= sw_cfg.cs_undervoltage_lockout_high_sel;
    end
  end

  assign cfg_r = {uv_chk_en_r, ov_chk_en_r, win_sel_r, disch_en_r, undervoltage_lockout_high_r};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_shift_r <= '0;
    end else if (boot_r) begin
      hi_shift_r <= nvm_win_high_shift;
    end else if (sw_shift_we) begin
      hi_shift_r <= sw_win_high_shift;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lo_shift_r <= '0;
    end else if (boot_r) begin
      lo_shift_r <= nvm_win_low_shift;
    end else if (sw_shift_we) begin
      lo_shift_r <= sw_win_low_shift;
    end
  end

  // window bounds for the analog comparators
  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_high_pct <= (SHIFT_W+1)'(`PPC_WIN_NOM_PCT);
    end else begin
      win_high_pct <= clamp_pct(hi_shift_r);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_low_pct <= (SHIFT_W+1)'(`PPC_WIN_NOM_PCT);
    end else begin
      win_low_pct <= clamp_pct(lo_shift_r);
    end
  end

  // bus and supply conditions
  logic bus_ok;
  logic supply_ok;
  logic src_role;
  logic src_go;
  logic snk_go;

  always_comb begin
    bus_ok = bus_cond(cfg_r, mon);
    src_role = (power_role != PPC_ROLE_SNK);
    supply_ok = supply_cond(cfg_r, mon, src_role);
  end

  // source enable: supply checks qualify assertion only; hold on bus
  logic src_on_r;

  always_comb begin
    if (!is_src_state(cc_fsm_state_report) || !bus_ok || boot_r) begin
      src_go = 1'b0;
    end else if (src_on_r) begin
      src_go = 1'b1;
    end else begin
      src_go = supply_ok;
    end
    snk_go = is_snk_state(cc_fsm_state_report) && bus_ok && !boot_r;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_on_r <= 1'b0;
    end else begin
      src_on_r <= src_go;
    end
  end

  ppc_od_driver u_src_drv (
    .core_clk(core_clk),
    .rst(rst),
    .assert_req(src_go),
    .pin(source_power_path_enable)
  );

  ppc_od_driver u_snk_drv (
    .core_clk(core_clk),
    .rst(rst),
    .assert_req(snk_go),
    .pin(sink_power_path_enable)
  );

  // attached source entry permission for the attach machine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_entry_allowed <= 1'b0;
    end else begin
      src_entry_allowed <= connect_detect && mon.bus_vsafe0v;
    end
  end

  // cable supply switching onto the unwired line
  logic cs_ok;
  logic cs_go;

  always_comb begin
    cs_ok = cs_role_ok(power_role, cc_fsm_state_report)
      && cs_switch_en && sink_connected
      && cable_supply_input_above_lockout;
    cs_go = cs_ok && !boot_r;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_to_cc1 <= 1'b0;
    end else begin
      cs_to_cc1 <= cs_go && !cc1_is_wired && ra_on_cc1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_to_cc2 <= 1'b0;
    end else begin
      cs_to_cc2 <= cs_go && cc1_is_wired && ra_on_cc2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_undervoltage_lockout_high_sel <= `PPC_UNDERVOLTAGE_LOCKOUT_HIGH_SEL;
    end else begin
      cs_undervoltage_lockout_high_sel <= cfg_r.cs_undervoltage_lockout_high_sel;
    end
  end

  // discharge after sink detach in source and DRP roles
  logic sink_seen_r;
  logic detach_pulse;
  logic disch_active;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sink_seen_r <= 1'b0;
    end else begin
      sink_seen_r <= sink_connected;
    end
  end

  assign detach_pulse = sink_seen_r && !sink_connected && (power_role != PPC_ROLE_SNK)
    && cfg_r.cs_discharge_en;

  ppc_disch_timer #(
    .CYCLES(DISCH_CYCLES)
  ) u_disch (
    .core_clk(core_clk),
    .rst(rst),
    .start(detach_pulse),
    .abort(power_role == PPC_ROLE_SNK),
    .active(disch_active)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_discharge <= 1'b0;
    end else begin
      cs_discharge <= disch_active;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_status <= '0;
    end else begin
      cfg_status <= cfg_r;
    end
  end
endmodule : ppc_power_path_ctrl

/* File: sim/ppc_sw_model.sv */
// Purpose: external bus power switch behind an enable pin
// Assumes: gate pulled up, so a released pin turns the switch off
// Notes: none
`timescale 1ns/10ps
module ppc_sw_model
  import ppc_pkg::*;
(
  input ppc_od_t pin,
  output logic switch_on
);
  // on only while the pin is pulled low
  assign switch_on = pin.drive_oe && !pin.drive_o;
endmodule : ppc_sw_model

/* File: sim/ppc_ctrl_chk.sv */
// Purpose: port checker for the power path control block
// Assumes: one clock domain, bound to the top module
// Notes: discharge length counted in helper logic
`timescale 1ns/10ps
module ppc_ctrl_chk
  import ppc_pkg::*;
#(
  parameter int unsigned DISCH_CYCLES = 20
) (
  input logic core_clk,
  input logic rst,
  input ppc_attach_t cc_fsm_state_report,
  input ppc_role_t power_role,
  input ppc_mon_t mon,
  input logic connect_detect,
  input logic cs_switch_en,
  input logic sink_connected,
  input logic ra_on_cc2,
  input logic cc1_is_wired,
  input logic cable_supply_input_above_lockout,
  input ppc_od_t source_power_path_enable,
  input ppc_od_t sink_power_path_enable,
  input logic cs_to_cc1,
  input logic cs_to_cc2,
  input logic cs_discharge,
  input logic src_entry_allowed,
  input ppc_cfg_t cfg_status
);
  logic [31:0] hi_cnt_r;
  logic src_st;
  logic snk_st;
  logic src_oe;
  logic snk_oe;
  assign src_st = cc_fsm_state_report inside {PPC_ATTACHED_SRC, PPC_UNOR_DBG_SRC, PPC_OR_DBG_SRC};
  assign snk_st = cc_fsm_state_report inside {PPC_ATTACHED_SNK, PPC_DBG_SNK};
  assign src_oe = source_power_path_enable.drive_oe;
  assign snk_oe = sink_power_path_enable.drive_oe;
  always_ff @(posedge core_clk) begin
    if (rst || !cs_discharge) begin
      hi_cnt_r <= 32'h0000_0000;
    end else begin
      hi_cnt_r <= hi_cnt_r + 32'h0000_0001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_NEVER_HIGH: assert property (!source_power_path_enable.drive_o && !sink_power_path_enable.drive_o)
    else $error("enable pin driven high");
  AST_SRC_STATE: assert property (src_oe |-> $past(src_st))
    else $error("source enable outside source states");
  AST_SRC_LEAVE: assert property (!src_st |=> !src_oe)
    else $error("source enable kept after leaving state");
  AST_BUS_FAIL: assert property (!mon.bus_in_window && !mon.bus_above_uv |=> !src_oe && !snk_oe)
    else $error("enable kept with bus invalid");
  AST_SNK_STATE: assert property (snk_oe |-> $past(snk_st))
    else $error("sink enable outside sink states");
  AST_CS_SNK_ROLE: assert property (power_role == PPC_ROLE_SNK |=> !cs_to_cc1 && !cs_to_cc2)
    else $error("cable supply in sink role");
  AST_CS_LOCKOUT: assert property (!cable_supply_input_above_lockout |=> !cs_to_cc1 && !cs_to_cc2)
    else $error("cable supply below lockout");
  AST_CS_CC2: assert property (cs_to_cc2 |-> $past(cs_switch_en && sink_connected && ra_on_cc2 && cc1_is_wired))
    else $error("cable supply on cc2 without cause");
  AST_ENTRY: assert property (src_entry_allowed |-> $past(connect_detect && mon.bus_vsafe0v))
    else $error("entry allowed without safe bus");
  AST_DISCH_LEN: assert property ($fell(cs_discharge) |-> hi_cnt_r == DISCH_CYCLES)
    else $error("discharge length wrong");
  AST_DISCH_START: assert property ($fell(sink_connected) && power_role != PPC_ROLE_SNK
    |=> (cfg_status.cs_discharge_en |-> ##1 cs_discharge))
    else $error("discharge not started");
  COV_SRC: cover property ($rose(src_oe));
  COV_CS: cover property ($rose(cs_to_cc2));
  COV_DISCH: cover property ($rose(cs_discharge));
endmodule : ppc_ctrl_chk

/* File: sim/tb.sv */
// Purpose: self-checking bench for the power path control block
// Assumes: inputs driven at the falling edge
// Notes: discharge shortened to 20 cycles
`timescale 1ns/10ps
module tb
  import ppc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  ppc_attach_t cc_fsm_state_report = PPC_UNATTACHED;
  ppc_role_t power_role = PPC_ROLE_SRC;
  ppc_mon_t mon = 5'h00;
  ppc_cfg_t nvm_default = 5'h17;
  ppc_cfg_t sw_cfg = 5'h00;
  logic sw_cfg_we = 1'b0, sw_shift_we = 1'b0, connect_detect = 1'b0, cs_switch_en = 1'b0;
  logic sink_connected = 1'b0, ra_on_cc1 = 1'b0, ra_on_cc2 = 1'b0, cc1_is_wired = 1'b0;
  logic cable_supply_input_above_lockout = 1'b0;
  logic [3:0] nvm_win_high_shift = 4'h0, nvm_win_low_shift = 4'h0;
  logic [3:0] sw_win_high_shift = 4'h0, sw_win_low_shift = 4'h0;
  ppc_od_t source_power_path_enable, sink_power_path_enable;
  logic cs_to_cc1, cs_to_cc2, cs_discharge, cs_undervoltage_lockout_high_sel, src_entry_allowed, src_on, snk_on;
  logic [4:0] win_high_pct, win_low_pct;
  ppc_cfg_t cfg_status;
  int bad_count = 0;
  int check_count = 0;

  ppc_power_path_ctrl #(.DISCH_CYCLES(20)) dut (.*);
  ppc_sw_model u_src_sw (.pin(source_power_path_enable), .switch_on(src_on));
  ppc_sw_model u_snk_sw (.pin(sink_power_path_enable), .switch_on(snk_on));

  always #2.5 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wcfg(input ppc_cfg_t v);
    sw_cfg = v;
    sw_cfg_we = 1'b1;
    cyc(1);
    sw_cfg_we = 1'b0;
    cyc(2);
  endtask : wcfg

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(3);
    chk(cfg_status, 5'h17);
    chk(cs_undervoltage_lockout_high_sel, 1'b1);
    chk(win_high_pct, 5'h05);
    $display("test defaults done");
    mon = 5'h0E;
    cc_fsm_state_report = PPC_ATTACHED_SRC;
    cyc(2);
    chk(src_on, 1'b0);
    mon.supply_above_uv = 1'b1;
    cyc(2);
    chk(src_on, 1'b1);
    mon.supply_above_uv = 1'b0;
    cyc(2);
    chk(src_on, 1'b1);
    mon.bus_in_window = 1'b0;
    cyc(2);
    chk(src_on, 1'b0);
    mon.supply_above_uv = 1'b1;
    wcfg(5'h13);
    chk(cfg_status, 5'h13);
    chk(src_on, 1'b1);
    for (int i = 0; i < 9; i++) begin
      cc_fsm_state_report = ppc_attach_t'(i);
      cyc(2);
      chk(src_on, i inside {2, 3, 4});
      chk(snk_on, i inside {6, 7});
    end
    power_role = PPC_ROLE_SNK;
    mon.supply_above_uv = 1'b0;
    cc_fsm_state_report = PPC_ATTACHED_SRC;
    cyc(2);
    chk(src_on, 1'b1);
    $display("test enables done");
    power_role = PPC_ROLE_SRC;
    mon.supply_above_uv = 1'b1;
    {cs_switch_en, sink_connected, ra_on_cc2, cc1_is_wired, cable_supply_input_above_lockout} = 5'h1F;
    cyc(2);
    chk({cs_to_cc1, cs_to_cc2}, 2'h1);
    cable_supply_input_above_lockout = 1'b0;
    cyc(2);
    chk(cs_to_cc2, 1'b0);
    cable_supply_input_above_lockout = 1'b1;
    power_role = PPC_ROLE_SNK;
    cyc(2);
    chk(cs_to_cc2, 1'b0);
    power_role = PPC_ROLE_DRP;
    cc1_is_wired = 1'b0;
    ra_on_cc1 = 1'b1;
    cyc(2);
    chk({cs_to_cc1, cs_to_cc2}, 2'h2);
    power_role = PPC_ROLE_SRC;
    sink_connected = 1'b0;
    cyc(3);
    chk(cs_discharge, 1'b1);
    cyc(20);
    chk(cs_discharge, 1'b0);
    wcfg(5'h10);
    chk(cs_undervoltage_lockout_high_sel, 1'b0);
    sink_connected = 1'b1;
    cyc(2);
    sink_connected = 1'b0;
    cyc(3);
    chk(cs_discharge, 1'b0);
    $display("test cable supply done");
    {sw_win_high_shift, sw_win_low_shift} = 8'h3F;
    sw_shift_we = 1'b1;
    cyc(1);
    sw_shift_we = 1'b0;
    cyc(2);
    chk({win_high_pct, win_low_pct}, 10'h114);
    connect_detect = 1'b1;
    mon.bus_vsafe0v = 1'b1;
    cyc(2);
    chk(src_entry_allowed, 1'b1);
    mon.bus_vsafe0v = 1'b0;
    cyc(2);
    chk(src_entry_allowed, 1'b0);
    $display("test window and entry done");
    wrap_up();
  end

  initial begin
    #5000;
    bad_count++;
    wrap_up();
  end
endmodule : tb

bind ppc_power_path_ctrl ppc_ctrl_chk #(.DISCH_CYCLES(DISCH_CYCLES)) u_chk (.*);
